/* tlvp_nest_stack.sv */
// Purpose: remaining-byte counters for open templates
// Assumes: one consume per accepted byte at most
// Notes: all levels count down together on each consumed byte
`timescale 1ns/1ps
module tlvp_nest_stack
	import tlvp_pkg::*;
#(
	parameter int DEPTH = TLVP_MAX_DEPTH
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic consume,
	input wire logic push,
	input wire logic [15:0] push_len,
	output logic [3:0] level,
	output logic top_zero,
	output logic full,
	output logic overrun
);
	logic [15:0] remain [DEPTH];
	logic [3:0] next_level;
	logic [3:0] pops;
	int i;

	// count of levels that close after this byte
	always_comb
	begin
		pops = 4'h0;
		for (i = 0; i < DEPTH; i++)
			if (4'(i) < level && consume && remain[i] == TLVP_ONE16)
				pops = pops + 4'h1;
		next_level = level - pops + {3'h0, push};
	end

	// per-level countdown, new level loaded on push
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			for (int k = 0; k < DEPTH; k++)
				remain[k] <= TLVP_ZERO16;
		else
			for (int k = 0; k < DEPTH; k++)
				if (push && 4'(k) == level - pops)
					remain[k] <= push_len;
				else if (consume && 4'(k) < level && remain[k] != TLVP_ZERO16)
					remain[k] <= remain[k] - TLVP_ONE16;
	end

	// depth register
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			level <= 4'h0;
		else
			level <= next_level;
	end

	assign top_zero = (level == 4'h0);
	assign full = (level == 4'(DEPTH));
	// a child longer than its parent's remaining bytes
	always_comb
	begin
		overrun = 1'b0;
		for (int k = 0; k < DEPTH; k++)
			if (4'(k) < level && push_len > remain[k] - 16'(consume))
				overrun = 1'b1;
	end
endmodule // tlvp_nest_stack

/* tlvp_parser.sv */
// Purpose: stream parser for tag-length-value data objects
// Assumes: upstream byte source on the same clock, valid/ready handshake
// Notes: headers go out on hdr_valid, value bytes on val_valid with last marker
`timescale 1ns/1ps
module tlvp_parser
	import tlvp_pkg::*;
#(
	parameter int DEPTH = TLVP_MAX_DEPTH
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	output logic hdr_valid,
	output tlvp_hdr_t hdr,
	output logic val_valid,
	output tlvp_beat_t val,
	output logic obj_end,
	output logic err_tag_long,
	output logic err_len_long,
	output logic err_overrun,
	output logic err_flag,
	output logic unexpected_tag
);
	typedef enum logic [5:0]
	{
		ST_TAG1 = 6'h01,
		ST_TAG2 = 6'h02,
		ST_LEN1 = 6'h04,
		ST_LENX = 6'h08,
		ST_VAL = 6'h10,
		ST_ERR = 6'h20
	} tlvp_state_t;

	tlvp_state_t state;
	tlvp_state_t next_state;
	logic take;
	logic [7:0] tag_hi;
	logic [15:0] tag_full;
	logic two_byte;
	logic cons;
	logic [1:0] cls;
	logic [1:0] len_left;
	logic [15:0] len_acc;
	logic [15:0] val_left;
	logic [15:0] fin_len;
	logic fin_hdr;
	logic descend;
	logic st_consume;
	logic st_push;
	logic [3:0] st_level;
	logic st_top_zero;
	logic st_full;
	logic st_overrun;
	tlvp_res_t res;
	logic is_tmpl;
	logic next_err_tag;
	logic next_err_len;

	assign take = in_valid && in_ready;

	// tag range checks
	tlvp_tag_class u_class
	(
		.tag(tag_full),
		.two_byte(two_byte),
		.constructed(cons),
		.res(res),
		.is_template(is_tmpl)
	);

	// lengths of open templates
	tlvp_nest_stack #(.DEPTH(DEPTH)) u_stack
	(
		.clock(clock),
		.arst_n(arst_n),
		.consume(take),
		.push(st_push),
		.push_len(fin_len),
		.level(st_level),
		.top_zero(st_top_zero),
		.full(st_full),
		.overrun(st_overrun)
	);

	// header completion and length result
	always_comb
	begin
		fin_hdr = 1'b0;
		fin_len = len_acc;
		next_err_tag = 1'b0;
		next_err_len = 1'b0;
		if (take && state == ST_LEN1 && !in_data[TLVP_MORE_BIT])
		begin
			fin_hdr = 1'b1;
			fin_len = {9'h000, in_data[6:0]};
		end
		else if (take && state == ST_LEN1 && in_data[TLVP_MORE_BIT])
		begin
			// more than two following bytes cannot fit three-byte limit
			if (in_data[6:0] > {4'h0, TLVP_MAX_LEN_BYTES} || in_data[6:0] == 7'h00)
				next_err_len = 1'b1;
		end
		else if (take && state == ST_LENX && len_left == 2'h1)
		begin
			fin_hdr = 1'b1;
			fin_len = {len_acc[7:0], in_data};
		end
		if (take && state == ST_TAG2 && (in_data[TLVP_MORE_BIT] || in_data[6:0] == 7'h00))
			next_err_tag = 1'b1;
	end

	// descend into constructed, non-private objects with a value
	assign descend = fin_hdr && (cons || is_tmpl) && cls != TLVP_CLASS_PRIV &&
		fin_len != TLVP_ZERO16;
	assign st_push = descend && !st_full;
	assign st_consume = take;

	// next state
	always_comb
	begin
		next_state = state;
		case (state)
			ST_TAG1:
				if (take)
					next_state = (in_data[4:0] == TLVP_TAG_EXT) ? ST_TAG2 : ST_LEN1;
			ST_TAG2:
				if (take)
					next_state = next_err_tag ? ST_ERR : ST_LEN1;
			ST_LEN1:
				if (next_err_len)
					next_state = ST_ERR;
				else if (take && in_data[TLVP_MORE_BIT])
					next_state = ST_LENX;
				else if (take)
					next_state = (descend || fin_len == TLVP_ZERO16) ? ST_TAG1 : ST_VAL;
			ST_LENX:
				if (take && len_left == 2'h1)
					next_state = (descend || fin_len == TLVP_ZERO16) ? ST_TAG1 : ST_VAL;
			ST_VAL:
				if (take && val_left == TLVP_ONE16)
					next_state = ST_TAG1;
			ST_ERR:
				next_state = ST_ERR;
			default:
				next_state = ST_ERR;
		endcase
		if (fin_hdr && (st_overrun || (descend && st_full)))
			next_state = ST_ERR;
	end

	// state register
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			state <= ST_TAG1;
		else
			state <= next_state;
	end

	// tag capture
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tag_hi <= 8'h00;
			tag_full <= TLVP_ZERO16;
			two_byte <= 1'b0;
			cons <= 1'b0;
			cls <= TLVP_CLASS_UNIV;
		end
		else if (take && state == ST_TAG1)
		begin
			tag_hi <= in_data;
			tag_full <= {8'h00, in_data};
			two_byte <= 1'b0;
			cons <= in_data[TLVP_CONS_BIT];
			cls <= {in_data[TLVP_CLASS_HI], in_data[TLVP_CLASS_LO]};
		end
		else if (take && state == ST_TAG2)
		begin
			tag_full <= {tag_hi, in_data};
			two_byte <= 1'b1;
		end
	end

	// length accumulation
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			len_left <= 2'h0;
			len_acc <= TLVP_ZERO16;
		end
		else if (take && state == ST_LEN1)
		begin
			len_left <= in_data[1:0];
			len_acc <= TLVP_ZERO16;
		end
		else if (take && state == ST_LENX)
		begin
			len_left <= len_left - 2'h1;
			len_acc <= {len_acc[7:0], in_data};
		end
	end

	// value byte counter
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			val_left <= TLVP_ZERO16;
		else if (fin_hdr)
			val_left <= fin_len;
		else if (take && state == ST_VAL)
			val_left <= val_left - TLVP_ONE16;
	end

	// input acceptance; halted after an error
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			in_ready <= 1'b0;
		else
			in_ready <= (next_state != ST_ERR);
	end

	// header strobe
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hdr_valid <= 1'b0;
			hdr <= '0;
			unexpected_tag <= 1'b0;
		end
		else
		begin
			hdr_valid <= fin_hdr;
			if (fin_hdr)
			begin
				hdr.tag <= tag_full;
				hdr.cls <= cls;
				hdr.constructed <= cons || is_tmpl;
				hdr.opaque <= (cls == TLVP_CLASS_PRIV);
				hdr.res <= res;
				hdr.length <= fin_len;
				hdr.depth <= st_level;
				unexpected_tag <= (res == TLVP_RES_UNUSED);
			end
		end
	end

	// value bytes with end marker
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			val_valid <= 1'b0;
			val <= '0;
			obj_end <= 1'b0;
		end
		else
		begin
			val_valid <= take && state == ST_VAL;
			val.data <= in_data;
			val.last <= take && state == ST_VAL && val_left == TLVP_ONE16;
			// end of object: last value byte, header with no value bytes, or header that descends into a constructed object
			obj_end <= (take && state == ST_VAL && val_left == TLVP_ONE16) ||
				(fin_hdr && (fin_len == TLVP_ZERO16 || descend));
		end
	end

	// sticky error flags, cleared only by reset
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_tag_long <= 1'b0;
			err_len_long <= 1'b0;
			err_overrun <= 1'b0;
			err_flag <= 1'b0;
		end
		else
		begin
			if (next_err_tag)
				err_tag_long <= 1'b1;
			if (next_err_len)
				err_len_long <= 1'b1;
			if (fin_hdr && (st_overrun || (descend && st_full)))
				err_overrun <= 1'b1;
			if (next_state == ST_ERR)
				err_flag <= 1'b1;
		end
	end
endmodule // tlvp_parser

/* tlvp_parser_sva.sv */
// Purpose: port-level checks for the tag-length-value parser
// Assumes: one clock, asynchronous active-low reset
// Notes: bound into every parser instance
`timescale 1ns/1ps
module tlvp_parser_chk
	import tlvp_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_ready,
	input wire logic hdr_valid,
	input wire tlvp_hdr_t hdr,
	input wire logic val_valid,
	input wire tlvp_beat_t val,
	input wire logic obj_end,
	input wire logic err_tag_long,
	input wire logic err_len_long,
	input wire logic err_overrun,
	input wire logic err_flag,
	input wire logic unexpected_tag
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	// strobes and their causes
	hdr_pulse_a: assert property (hdr_valid |=> !hdr_valid)
		else $error("header strobe longer than one cycle");
	val_take_a: assert property (val_valid |-> $past(in_valid && in_ready))
		else $error("value byte without a taken input byte");
	last_end_a: assert property (val_valid && val.last |-> obj_end)
		else $error("final value byte without end marker");
	zero_end_a: assert property (hdr_valid && hdr.length == 16'h0000 |-> obj_end)
		else $error("empty object without end marker");
	// errors stop intake for good
	err_hold_a: assert property (err_flag |=> err_flag && !in_ready)
		else $error("error not sticky or intake still open");
	// header classification
	priv_opaque_a: assert property (hdr_valid |-> hdr.opaque == (hdr.cls == TLVP_CLASS_PRIV))
		else $error("opaque flag does not follow private class");
	templ_cons_a: assert property (hdr_valid && hdr.tag inside {16'h0061, 16'h006F}
		|-> hdr.constructed)
		else $error("standard template not constructed");
	unexp_tag_a: assert property (hdr_valid |-> unexpected_tag ==
		(hdr.tag inside {16'h0078, 16'h0079, 16'h007D, 16'h007E}))
		else $error("unexpected tag flag wrong");
	pay_res_a: assert property (hdr_valid && !hdr.constructed
		&& hdr.tag inside {[TLVP_PAY_LO:TLVP_PAY_HI]} |-> hdr.res == TLVP_RES_PAY)
		else $error("payment range tag misclassified");
endmodule // tlvp_parser_chk

bind tlvp_parser tlvp_parser_chk u_chk (.clock(clock), .arst_n(arst_n), .in_valid(in_valid),
	.in_data(in_data), .in_ready(in_ready), .hdr_valid(hdr_valid), .hdr(hdr),
	.val_valid(val_valid), .val(val), .obj_end(obj_end), .err_tag_long(err_tag_long),
	.err_len_long(err_len_long), .err_overrun(err_overrun), .err_flag(err_flag),
	.unexpected_tag(unexpected_tag));

/* tlvp_parser_tb_top.sv */
// Purpose: self-checking bench for the parser
// Assumes: bytes come from tlvp_src
// Notes: table of single objects, then nesting, stalls, errors
`timescale 1ns/1ps
module tlvp_parser_tb_top;
	import tlvp_pkg::*;
	typedef struct packed
	{
		logic [47:0] b;
		logic [2:0] n;
		logic [41:0] e;
	} tlvp_row_t;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	logic stall = 1'h0;
	logic in_valid, in_ready, hdr_valid, val_valid, obj_end, unexpected_tag;
	logic err_tag_long, err_len_long, err_overrun, err_flag;
	logic [7:0] in_data;
	tlvp_hdr_t hdr;
	tlvp_beat_t val;
	tlvp_row_t rows[8];
	logic [41:0] hq[$];
	logic [8:0] vq[$];
	logic [31:0] estr[3] = '{32'h9F810100, 32'h5A830000, 32'h70025A05};
	logic [4:0] eexp[3] = '{5'h12, 5'h0A, 5'h06};
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int n_end = 0;
	int n_unexp = 0;
	int n_opq = 0;

	tlvp_src src (.clock(clock), .arst_n(arst_n), .in_ready(in_ready), .stall(stall),
		.in_valid(in_valid), .in_data(in_data));
	tlvp_parser uut (.clock(clock), .arst_n(arst_n), .in_valid(in_valid), .in_data(in_data),
		.in_ready(in_ready), .hdr_valid(hdr_valid), .hdr(hdr), .val_valid(val_valid),
		.val(val), .obj_end(obj_end), .err_tag_long(err_tag_long),
		.err_len_long(err_len_long), .err_overrun(err_overrun), .err_flag(err_flag),
		.unexpected_tag(unexpected_tag));

	// 25 ns clock and a cycle ceiling
	initial forever #12.5 clock = ~clock;
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			complete_run();
		end
	end
	// collect headers and value bytes
	always @(posedge clock)
	begin
		if (hdr_valid)
			hq.push_back({hdr.depth, hdr.tag, hdr.cls, hdr.constructed, hdr.res, hdr.length});
		if (val_valid)
			vq.push_back({val.last, val.data});
		// end markers and header flags, counted
		if (obj_end)
			n_end++;
		if (hdr_valid && unexpected_tag)
			n_unexp++;
		if (hdr_valid && hdr.opaque)
			n_opq++;
	end

	task automatic chk_bits(string name, logic [41:0] exp, logic [41:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_hdr(logic [41:0] exp);
		chk_bits("header", exp, hq.size() > 0 ? hq.pop_front() : 'x);
	endtask
	task automatic chk_val(logic [7:0] d, logic last = 1'h1);
		chk_bits("value", {last, d}, vq.size() > 0 ? vq.pop_front() : 'x);
	endtask
	task automatic send(logic [47:0] b, int n);
		for (int k = 0; k < n; k++)
			src.q.push_back(b[47 - 8 * k -: 8]);
	endtask
	task automatic wait_idle();
		repeat (200)
			if (src.q.size() != 0)
				@(posedge clock);
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic do_reset();
		@(posedge clock);
		arst_n <= 1'h0;
		src.q.delete();
		repeat (16) @(posedge clock);
		chk_bits("reset outputs", 42'h0, {in_ready, hdr_valid, val_valid, obj_end, err_flag,
			err_tag_long, err_len_long, err_overrun, unexpected_tag});
		arst_n <= 1'h1;
		repeat (2) @(posedge clock);
		#1;
		hq.delete();
		vq.delete();
		n_end = 0;
		n_unexp = 0;
		n_opq = 0;
		chk_bits("ready after reset", 42'h1, in_ready);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		rows[0] = '{48'h9F0201AA0000, 3'h4, {4'h0, 16'h9F02, 2'h2, 1'h0, TLVP_RES_SPEC, 16'h0001}};
		rows[1] = '{48'h5A0000000000, 3'h2, {4'h0, 16'h005A, 2'h1, 1'h0, TLVP_RES_NONE, 16'h0000}};
		rows[2] = '{48'hC18101BB0000, 3'h4, {4'h0, 16'h00C1, 2'h3, 1'h0, TLVP_RES_NONE, 16'h0001}};
		rows[3] = '{48'h9F55820001CC, 3'h6, {4'h0, 16'h9F55, 2'h2, 1'h0, TLVP_RES_PAY, 16'h0001}};
		rows[4] = '{48'h610000000000, 3'h2, {4'h0, 16'h0061, 2'h1, 1'h1, TLVP_RES_ISO, 16'h0000}};
		rows[5] = '{48'h780000000000, 3'h2, {4'h0, 16'h0078, 2'h1, 1'h1, TLVP_RES_UNUSED, 16'h0000}};
		rows[6] = '{48'h800000000000, 3'h2, {4'h0, 16'h0080, 2'h2, 1'h0, TLVP_RES_SPEC, 16'h0000}};
		rows[7] = '{48'h1F1F00000000, 3'h3, {4'h0, 16'h1F1F, 2'h0, 1'h0, TLVP_RES_NONE, 16'h0000}};
		do_reset();
		// all rows back to back, then compare in order
		foreach (rows[i])
			send(rows[i].b, rows[i].n);
		wait_idle();
		foreach (rows[i])
			chk_hdr(rows[i].e);
		chk_val(8'hAA);
		chk_val(8'hBB);
		chk_val(8'hCC);
		// nested template, private constructed object, source gaps mid-object
		stall <= 1'h1;
		send(48'h70035A011100, 5);
		send(48'hE2025A000000, 4);
		repeat (5) @(posedge clock);
		stall <= 1'h0;
		repeat (2) @(posedge clock);
		stall <= 1'h1;
		repeat (3) @(posedge clock);
		stall <= 1'h0;
		wait_idle();
		chk_hdr({4'h0, 16'h0070, 2'h1, 1'h1, TLVP_RES_NONE, 16'h0003});
		chk_hdr({4'h1, 16'h005A, 2'h1, 1'h0, TLVP_RES_NONE, 16'h0001});
		chk_val(8'h11);
		chk_hdr({4'h0, 16'h00E2, 2'h3, 1'h1, TLVP_RES_NONE, 16'h0002});
		chk_val(8'h5A, 1'h0);
		chk_val(8'h00);
		chk_bits("end markers", 42'hB, n_end);
		chk_bits("unexpected tags", 42'h1, n_unexp);
		chk_bits("opaque headers", 42'h2, n_opq);
		chk_bits("leftover outputs", 42'h0, hq.size() + vq.size());
		// oversize tag, oversize length, overrun of the template
		for (int i = 0; i < 3; i++)
		begin
			do_reset();
			send({estr[i], 16'h0000}, 4);
			wait_idle();
			chk_bits("error flags", eexp[i], {err_tag_long, err_len_long, err_overrun,
				err_flag, in_ready});
		end
		complete_run();
	end
endmodule // tlvp_parser_tb_top

/* tlvp_pkg.sv */
// Purpose: shared constants and types for the tag-length-value parser
// Assumes: byte-wide input stream, single clock
// Notes: class codes, tag ranges and size limits live here
package tlvp_pkg;
	localparam int TLVP_MAX_DEPTH = 4;
	localparam logic [1:0] TLVP_CLASS_UNIV = 2'h0;
	localparam logic [1:0] TLVP_CLASS_APPL = 2'h1;
	localparam logic [1:0] TLVP_CLASS_CTX = 2'h2;
	localparam logic [1:0] TLVP_CLASS_PRIV = 2'h3;
	localparam logic [4:0] TLVP_TAG_EXT = 5'h1F;
	localparam int TLVP_CLASS_HI = 7;
	localparam int TLVP_CLASS_LO = 6;
	localparam int TLVP_CONS_BIT = 5;
	localparam int TLVP_MORE_BIT = 7;
	localparam logic [2:0] TLVP_MAX_LEN_BYTES = 3'h2;
	localparam logic [7:0] TLVP_TMPL_A = 8'h61;
	localparam logic [7:0] TLVP_TMPL_B = 8'h6F;
	localparam logic [7:0] TLVP_BAD_78 = 8'h78;
	localparam logic [7:0] TLVP_BAD_79 = 8'h79;
	localparam logic [7:0] TLVP_BAD_7D = 8'h7D;
	localparam logic [7:0] TLVP_BAD_7E = 8'h7E;
	localparam logic [15:0] TLVP_SPEC1_LO = 16'h0080;
	localparam logic [15:0] TLVP_SPEC1_HI = 16'h009E;
	localparam logic [15:0] TLVP_SPEC2_LO = 16'h9F00;
	localparam logic [15:0] TLVP_SPEC2_HI = 16'h9F4F;
	localparam logic [15:0] TLVP_PAY_LO = 16'h9F50;
	localparam logic [15:0] TLVP_PAY_HI = 16'h9F7F;
	localparam logic [15:0] TLVP_ZERO16 = 16'h0000;
	localparam logic [15:0] TLVP_ONE16 = 16'h0001;

	// reservation class of a completed tag
	typedef enum logic [2:0]
	{
		TLVP_RES_NONE = 3'h0,
		TLVP_RES_SPEC = 3'h1,
		TLVP_RES_PAY = 3'h2,
		TLVP_RES_UNUSED = 3'h3,
		TLVP_RES_ISO = 3'h4
	} tlvp_res_t;

	// header of one decoded object
	typedef struct packed
	{
		logic [15:0] tag;
		logic [1:0] cls;
		logic constructed;
		logic opaque;
		tlvp_res_t res;
		logic [15:0] length;
		logic [3:0] depth;
	} tlvp_hdr_t;

	// one value byte going downstream
	typedef struct packed
	{
		logic [7:0] data;
		logic last;
	} tlvp_beat_t;
endpackage

/* tlvp_src.sv */
// Purpose: upstream byte source feeding the parser
// Assumes: bench fills q with whole objects
// Notes: byte held until taken; idle data toggles
`timescale 1ns/1ps
module tlvp_src
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic in_ready,
	input wire logic stall,
	output logic in_valid,
	output logic [7:0] in_data
);
	logic [7:0] q[$];
	// hold a byte until in_ready takes it, then present the next
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			in_valid <= 1'h0;
			in_data <= 8'h00;
		end
		else if (!in_valid || in_ready)
		begin
			if (in_valid)
				void'(q.pop_front());
			in_valid <= q.size() > 0 && !stall;
			in_data <= (q.size() > 0 && !stall) ? q[0] : ~in_data;
		end
	end
endmodule // tlvp_src

/* tlvp_tag_class.sv */
// Purpose: classify a completed tag against the reserved ranges
// Assumes: tag right-aligned, one-byte tags in the low byte
// Notes: purely combinational
`timescale 1ns/1ps
module tlvp_tag_class
	import tlvp_pkg::*;
(
	input wire logic [15:0] tag,
	input wire logic two_byte,
	input wire logic constructed,
	output tlvp_res_t res,
	output logic is_template
);
	// range lookup for the finished tag
	always_comb
	begin
		res = TLVP_RES_NONE;
		is_template = 1'b0;
		if (!two_byte && (tag[7:0] == TLVP_TMPL_A || tag[7:0] == TLVP_TMPL_B))
		begin
			res = TLVP_RES_ISO;
			is_template = 1'b1;
		end
		else if (!two_byte && (tag[7:0] == TLVP_BAD_78 || tag[7:0] == TLVP_BAD_79 ||
			tag[7:0] == TLVP_BAD_7D || tag[7:0] == TLVP_BAD_7E))
			res = TLVP_RES_UNUSED;
		else if (!constructed && !two_byte && tag >= TLVP_SPEC1_LO && tag <= TLVP_SPEC1_HI)
			res = TLVP_RES_SPEC;
		else if (!constructed && two_byte && tag >= TLVP_SPEC2_LO && tag <= TLVP_SPEC2_HI)
			res = TLVP_RES_SPEC;
		else if (!constructed && two_byte && tag >= TLVP_PAY_LO && tag <= TLVP_PAY_HI)
			res = TLVP_RES_PAY;
	end
endmodule // tlvp_tag_class
